// ---- hw/fifo_build_options_and_thresholds.sv ----
// first-in-first-out buffer with build options, near-full and near-empty flags
// assumes producer and consumer logic on clock_i; no pin inputs to synchronise
//
// Behaviour
// - with the read clear option on, the clear is asserted at once and its release passes a read-clocked synchroniser first.
// - in dual-clock builds the pointer crossing stage count follows the clocks-related option, none when related; single-clock has none.
// - in dual-clock builds with unrelated clocks the two depth settings set the two crossings' stage counts.
// - each depth setting is reduced by two, so 3 gives one stage and 4 gives two.
// - the output register option adds a register stage on the read data.
// - dual-clock on newer targets ignores that option: registered normal, bare show-ahead.
// - single-clock near-full is set while the stored count is at or above its threshold.
// - single-clock near-empty is set while the stored count is below its threshold.
// - single-clock with combined-on-full on, a read plus write on a full buffer is taken and stays full.
// - with the overflow guard on, a write while full is ignored, save a single-clock read plus write under combined-on-full.
// - with the underflow guard on, a read while empty is ignored.
`timescale 1ns/1ns
`default_nettype none

// =======================================================================
// pointer delay line standing for a clock crossing
module ptr_delay
  import fifo_opts_pkg::*;
#(
  parameter int STAGES = 0
) (
  // clock and reset of the receiving side
  input wire logic clock_i,
  input wire logic rst_b_i,
  // pointer in, delayed view out
  input wire logic [PTR_W-1:0] ptr_i,
  output logic [PTR_W-1:0] view_o
);
  if (STAGES == 0) begin : g_direct
    assign view_o = ptr_i;
  end else begin : g_pipe
    logic [PTR_W-1:0] pipe_q [STAGES];
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
      // one stage of the crossing
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pipe_q[i] <= PTR_RESET;
        end else begin
          pipe_q[i] <= (i == 0) ? ptr_i : pipe_q[(i == 0) ? 0 : i-1];
        end
      end
    end
    assign view_o = pipe_q[STAGES-1];
  end
endmodule // ptr_delay

// =======================================================================
// storage, pointers, guards and flags
module fifo_core
  import fifo_opts_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter bit DUAL_CLOCK = 1'b0,
  parameter int WR_TO_RD_STAGES = 0,
  parameter int RD_TO_WR_STAGES = 0,
  parameter bit SHOW_AHEAD = 1'b0,
  parameter bit OVERFLOW_GUARD = 1'b1,
  parameter bit UNDERFLOW_GUARD = 1'b1,
  parameter bit WR_WHEN_FULL = 1'b0
) (
  // clock and per-side resets
  input wire logic clock_i,
  input wire logic wr_rst_b_i,
  input wire logic rd_rst_b_i,
  input wire logic sclr_i,
  // write side
  input wire logic wr_req_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  output logic [PTR_W-1:0] wr_used_o,
  // read side
  input wire logic rd_req_i,
  output logic rd_valid_o,
  output logic [PTR_W-1:0] rd_used_o,
  output logic [WIDTH-1:0] head_o,
  // thresholds and flags
  input wire logic [PTR_W-1:0] near_full_level_i,
  input wire logic [PTR_W-1:0] near_empty_level_i,
  output logic near_full_o,
  output logic near_empty_o
);
  localparam logic [PTR_W-1:0] DEPTH_W = PTR_W'(DEPTH);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [PTR_W-1:0] rd_view, wr_view, wr_used_d, rd_used_d;
  logic wr_ready_q, rd_valid_q, near_full_q, near_empty_q;
  logic [PTR_W-1:0] wr_used_q, rd_used_q;
  logic [WIDTH-1:0] head_q;
  logic wr_go, rd_go;

  // accepted requests under the guards
  assign rd_go = rd_req_i && (rd_valid_q || !UNDERFLOW_GUARD);
  assign wr_go = wr_req_i && (wr_ready_q || !OVERFLOW_GUARD
                 || (WR_WHEN_FULL && !DUAL_CLOCK && rd_go));

  // next pointers
  assign wr_ptr_d = sclr_i ? PTR_RESET : wr_ptr_q + PTR_W'(wr_go);
  assign rd_ptr_d = sclr_i ? PTR_RESET : rd_ptr_q + PTR_W'(rd_go);

  // crossings; zero stages gives the exact count of the single-clock variant
  ptr_delay #(.STAGES(RD_TO_WR_STAGES)) u_rd_to_wr (
    .clock_i(clock_i), .rst_b_i(wr_rst_b_i), .ptr_i(rd_ptr_d), .view_o(rd_view));
  ptr_delay #(.STAGES(WR_TO_RD_STAGES)) u_wr_to_rd (
    .clock_i(clock_i), .rst_b_i(rd_rst_b_i), .ptr_i(wr_ptr_d), .view_o(wr_view));

  // counts as seen by each side, in the cycle they update
  assign wr_used_d = wr_ptr_d - rd_view;
  assign rd_used_d = wr_view - rd_ptr_d;

  // storage write
  always_ff @(posedge clock_i) begin
    if (wr_go) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_data_i;
    end
  end

  // write-side state and flags
  always_ff @(posedge clock_i or negedge wr_rst_b_i) begin
    if (!wr_rst_b_i) begin
      wr_ptr_q <= PTR_RESET;
      wr_used_q <= PTR_RESET;
      wr_ready_q <= !FULL_RESET;
      near_full_q <= NEAR_FULL_RESET;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      wr_used_q <= wr_used_d;
      wr_ready_q <= (wr_used_d != DEPTH_W);
      near_full_q <= (wr_used_d >= near_full_level_i);
    end
  end

  // read-side state and flags
  always_ff @(posedge clock_i or negedge rd_rst_b_i) begin
    if (!rd_rst_b_i) begin
      rd_ptr_q <= PTR_RESET;
      rd_used_q <= PTR_RESET;
      rd_valid_q <= !EMPTY_RESET;
      near_empty_q <= NEAR_EMPTY_RESET;
    end else begin
      rd_ptr_q <= rd_ptr_d;
      rd_used_q <= rd_used_d;
      rd_valid_q <= (rd_used_d != PTR_RESET);
      near_empty_q <= (rd_used_d < near_empty_level_i);
    end
  end

  // head data: on a read in normal mode, always the next word in show-ahead
  always_ff @(posedge clock_i or negedge rd_rst_b_i) begin
    if (!rd_rst_b_i) begin
      head_q <= DATA_RESET;
    end else if (SHOW_AHEAD) begin
      if (wr_go && (wr_ptr_q[AW-1:0] == rd_ptr_d[AW-1:0])) begin
        head_q <= wr_data_i; // bypass a word landing at the head
      end else begin
        head_q <= mem_q[rd_ptr_d[AW-1:0]];
      end
    end else if (rd_go) begin
      head_q <= mem_q[rd_ptr_q[AW-1:0]];
    end
  end

  assign wr_ready_o = wr_ready_q;
  assign rd_valid_o = rd_valid_q;
  assign wr_used_o = wr_used_q;
  assign rd_used_o = rd_used_q;
  assign near_full_o = near_full_q;
  assign near_empty_o = near_empty_q;
  assign head_o = head_q;
endmodule // fifo_core

// =======================================================================
// top: clear synchroniser, option decoding and output stage
module fifo_build_options_and_thresholds
  import fifo_opts_pkg::*;
#(
  parameter bit DUAL_CLOCK = 1'b0,
  parameter bit NEW_TARGET = 1'b1,
  parameter bit READ_ACLR_SYNC = 1'b0,
  parameter bit CLOCKS_RELATED = 1'b0,
  parameter int WR_TO_RD_PIPE = SYNC_PIPE_DEFAULT,
  parameter int RD_TO_WR_PIPE = SYNC_PIPE_DEFAULT,
  parameter bit OUTPUT_REG = 1'b0,
  parameter bit SHOW_AHEAD = 1'b0,
  parameter bit OVERFLOW_GUARD = 1'b1,
  parameter bit UNDERFLOW_GUARD = 1'b1,
  parameter bit WR_WHEN_FULL = 1'b0
) (
  // clock, asynchronous and synchronous clear
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic sclr_i,
  // write side
  input wire logic wr_req_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  output logic wr_ready_o,
  output logic [PTR_W-1:0] wr_used_o,
  // read side
  input wire logic rd_req_i,
  output logic rd_valid_o,
  output logic [PTR_W-1:0] rd_used_o,
  output logic [DATA_W-1:0] rd_data_o,
  // thresholds and flags
  input wire logic [PTR_W-1:0] near_full_level_i,
  input wire logic [PTR_W-1:0] near_empty_level_i,
  output logic near_full_o,
  output logic near_empty_o
);
  localparam int WR_TO_RD_ST = cross_stages(DUAL_CLOCK, CLOCKS_RELATED, WR_TO_RD_PIPE);
  localparam int RD_TO_WR_ST = cross_stages(DUAL_CLOCK, CLOCKS_RELATED, RD_TO_WR_PIPE);
  localparam bit DATA_REG = (DUAL_CLOCK && NEW_TARGET) ? !SHOW_AHEAD : OUTPUT_REG;

  logic rd_rst_b;
  logic [DATA_W-1:0] head;

  // read-side clear: asserted at once, released through read-clocked flops
  if (READ_ACLR_SYNC) begin : g_aclr_sync
    logic [ACLR_SYNC_STAGES-1:0] sync_q;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        sync_q <= '0;
      end else begin
        sync_q <= {sync_q[ACLR_SYNC_STAGES-2:0], 1'b1};
      end
    end
    assign rd_rst_b = sync_q[ACLR_SYNC_STAGES-1];
  end else begin : g_aclr_direct
    assign rd_rst_b = rst_b_i;
  end

  fifo_core #(
    .WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .DUAL_CLOCK(DUAL_CLOCK),
    .WR_TO_RD_STAGES(WR_TO_RD_ST), .RD_TO_WR_STAGES(RD_TO_WR_ST),
    .SHOW_AHEAD(SHOW_AHEAD), .OVERFLOW_GUARD(OVERFLOW_GUARD),
    .UNDERFLOW_GUARD(UNDERFLOW_GUARD), .WR_WHEN_FULL(WR_WHEN_FULL)
  ) u_core (
    .clock_i(clock_i), .wr_rst_b_i(rst_b_i), .rd_rst_b_i(rd_rst_b), .sclr_i(sclr_i),
    .wr_req_i(wr_req_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
    .wr_used_o(wr_used_o), .rd_req_i(rd_req_i), .rd_valid_o(rd_valid_o),
    .rd_used_o(rd_used_o), .head_o(head),
    .near_full_level_i(near_full_level_i), .near_empty_level_i(near_empty_level_i),
    .near_full_o(near_full_o), .near_empty_o(near_empty_o));

  // optional extra register stage on the read data
  if (DATA_REG) begin : g_out_reg
    logic [DATA_W-1:0] data_q;
    always_ff @(posedge clock_i or negedge rd_rst_b) begin
      if (!rd_rst_b) begin
        data_q <= DATA_RESET;
      end else begin
        data_q <= head;
      end
    end
    assign rd_data_o = data_q;
  end else begin : g_out_bare
    assign rd_data_o = head;
  end
endmodule // fifo_build_options_and_thresholds

`default_nettype wire

// ---- shared/fifo_opts_pkg.sv ----
// constants shared by the buffer with build options and its bench
// assumes a single 20 MHz clock and an active-low asynchronous clear
package fifo_opts_pkg;

  // =====================================================================
  // geometry
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W = 5;
  localparam int PTR_W = ADDR_W + 1;

  // =====================================================================
  // cross-domain stage settings
  localparam int SYNC_PIPE_DEFAULT = 3;
  localparam int SYNC_PIPE_REDUCE = 2;
  localparam int RELATED_STAGES = 0;
  localparam int ACLR_SYNC_STAGES = 2;

  // =====================================================================
  // reset values
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam logic FULL_RESET = 1'b0;
  localparam logic EMPTY_RESET = 1'b1;
  localparam logic NEAR_FULL_RESET = 1'b0;
  localparam logic NEAR_EMPTY_RESET = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // stage count of a pointer crossing from the build options
  function automatic int cross_stages(input bit dual, input bit related, input int pipe);
    if (!dual) begin
      return 0;
    end else if (related) begin
      return RELATED_STAGES;
    end else if (pipe > SYNC_PIPE_REDUCE) begin
      return pipe - SYNC_PIPE_REDUCE;
    end
    return 0;
  endfunction

endpackage

// ---- tb/fifo_build_options_and_thresholds_bench.sv ----
// self-checking bench for the buffer, single clock with combined-on-full on, plus a dual build
// assumes the checker is bound and stream_ends drives requests
`timescale 1ns/1ns
`default_nettype none
// ======================================================================
// bench top
module fifo_build_options_and_thresholds_bench;
  import fifo_opts_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sclr_i = 1'b0;
  logic wr_req, rd_req, wr_ready, rd_valid, near_full, near_empty;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [PTR_W-1:0] wr_used, rd_used;
  logic wr_req2, rd_req2, wr_ready2, rd_valid2, near_full2, near_empty2;
  logic [DATA_W-1:0] wr_data2, rd_data2;
  logic [PTR_W-1:0] wr_used2, rd_used2;
  logic [PTR_W-1:0] nf_level = 6'h04;
  logic [PTR_W-1:0] ne_level = 6'h02;
  int fails = 0;
  int num_checks = 0;

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  stream_ends far (.clock_i(clock_i), .wr_req_o(wr_req), .wr_data_o(wr_data), .rd_req_o(rd_req));

  // guard on beside combined-on-full
  fifo_build_options_and_thresholds #(.WR_WHEN_FULL(1'b1), .OVERFLOW_GUARD(1'b1)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .sclr_i(sclr_i),
    .wr_req_i(wr_req), .wr_data_i(wr_data), .wr_ready_o(wr_ready), .wr_used_o(wr_used),
    .rd_req_i(rd_req), .rd_valid_o(rd_valid), .rd_used_o(rd_used), .rd_data_o(rd_data),
    .near_full_level_i(nf_level), .near_empty_level_i(ne_level),
    .near_full_o(near_full), .near_empty_o(near_empty));

  stream_ends far2 (.clock_i(clock_i), .wr_req_o(wr_req2), .wr_data_o(wr_data2),
    .rd_req_o(rd_req2));

  // dual build on one clock: read clear synchronised, output option off yet registered
  fifo_build_options_and_thresholds #(.DUAL_CLOCK(1'b1), .READ_ACLR_SYNC(1'b1),
    .OUTPUT_REG(1'b0)) dut_dual (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .sclr_i(1'b0),
    .wr_req_i(wr_req2), .wr_data_i(wr_data2), .wr_ready_o(wr_ready2), .wr_used_o(wr_used2),
    .rd_req_i(rd_req2), .rd_valid_o(rd_valid2), .rd_used_o(rd_used2), .rd_data_o(rd_data2),
    .near_full_level_i(nf_level), .near_empty_level_i(ne_level),
    .near_full_o(near_full2), .near_empty_o(near_empty2));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    chk("ready", 8'h01, {7'h0, wr_ready});
    chk("near empty", 8'h01, {7'h0, near_empty});
    // dual build: write lands on the second edge after release
    far2.op(1'b1, 1'b0, 8'ha1);
    chk("dual used", 8'h01, {2'b00, wr_used2});
    chk("dual valid", 8'h00, {7'h0, rd_valid2});
    @(posedge clock_i);
    #1 chk("dual valid", 8'h00, {7'h0, rd_valid2});
    @(posedge clock_i);
    #1 chk("dual valid", 8'h01, {7'h0, rd_valid2});
    chk("dual ready", 8'h01, {7'h0, wr_ready2});
    far2.op(1'b0, 1'b1, 8'h00);
    chk("dual used", 8'h01, {2'b00, wr_used2});
    chk("dual rd used", 8'h00, {2'b00, rd_used2});
    chk("dual data", 8'h00, rd_data2);
    @(posedge clock_i);
    #1 chk("dual used", 8'h00, {2'b00, wr_used2});
    chk("dual data", 8'ha1, rd_data2);
    $display("dual test done");
    for (int k = 1; k <= 32; k++) begin
      far.op(1'b1, 1'b0, 8'(k));
      chk("used", 8'(k), {2'b00, wr_used});
      chk("near full", 8'(k >= 4), {7'h0, near_full});
      chk("near empty", 8'(k < 2), {7'h0, near_empty});
    end
    $display("fill test done");
    far.op(1'b1, 1'b0, 8'hee);
    chk("used", 8'h20, {2'b00, wr_used});
    far.op(1'b1, 1'b1, 8'h55);
    chk("used", 8'h20, {2'b00, wr_used});
    chk("ready", 8'h00, {7'h0, wr_ready});
    chk("data", 8'h01, rd_data);
    $display("full test done");
    for (int k = 2; k <= 33; k++) begin
      far.op(1'b0, 1'b1, 8'h00);
      chk("data", (k == 33) ? 8'h55 : 8'(k), rd_data);
      chk("near empty", 8'(k > 31), {7'h0, near_empty});
    end
    far.op(1'b0, 1'b1, 8'h00);
    chk("used", 8'h00, {2'b00, rd_used});
    chk("data", 8'h55, rd_data);
    $display("empty test done");
    far.op(1'b1, 1'b0, 8'h77);
    far.op(1'b1, 1'b0, 8'h78);
    @(posedge clock_i);
    #1 sclr_i = 1'b1;
    @(posedge clock_i);
    #1 sclr_i = 1'b0;
    chk("used", 8'h00, {2'b00, wr_used});
    chk("near empty", 8'h01, {7'h0, near_empty});
    chk("valid", 8'h00, {7'h0, rd_valid});
    $display("clear test done");
    end_of_test();
  end

  // watchdog, well past the roughly 160 cycles the tests need
  initial begin
    #(50 * 1000);
    fails++;
    end_of_test();
  end
endmodule // fifo_build_options_and_thresholds_bench
`default_nettype wire

// ---- tb/fifo_opts_chk.sv ----
// assertions on the ports of the buffer top
// assumes the synchronous clear is only pulsed on single-clock builds, bound to the top below
`timescale 1ns/1ns
`default_nettype none
// ======================================================================
// checker
module fifo_opts_chk
  import fifo_opts_pkg::*;
#(
  parameter bit WR_WHEN_FULL = 1'b0
) (
  // clock and clears
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic sclr_i,
  // write side
  input wire logic wr_req_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_ready_o,
  input wire logic [PTR_W-1:0] wr_used_o,
  // read side
  input wire logic rd_req_i,
  input wire logic rd_valid_o,
  input wire logic [PTR_W-1:0] rd_used_o,
  input wire logic [DATA_W-1:0] rd_data_o,
  // thresholds and flags
  input wire logic [PTR_W-1:0] near_full_level_i,
  input wire logic [PTR_W-1:0] near_empty_level_i,
  input wire logic near_full_o,
  input wire logic near_empty_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // refusals, steps and flag relations
  a_full_write_ignored: assert property (wr_req_i && !wr_ready_o && !rd_req_i && !sclr_i |=>
    wr_used_o == $past(wr_used_o)) else $error("write while full changed count");
  a_empty_read_ignored: assert property (rd_req_i && !rd_valid_o && !wr_req_i && !sclr_i |=>
    rd_used_o == $past(rd_used_o)) else $error("read while empty changed count");
  a_combined_stays_full: assert property (WR_WHEN_FULL && wr_req_i && rd_req_i && !wr_ready_o
    && !sclr_i |=> !wr_ready_o && wr_used_o == 6'h20) else $error("combined cycle left full");
  a_write_count_step: assert property (wr_req_i && wr_ready_o && !rd_req_i && !sclr_i |=>
    wr_used_o == $past(wr_used_o) + 6'h01) else $error("write did not add one");
  a_read_count_step: assert property (rd_req_i && rd_valid_o && !wr_req_i && !sclr_i |=>
    rd_used_o == $past(rd_used_o) - 6'h01) else $error("read did not remove one");
  a_near_full_level: assert property ($past(rst_b_i) && $stable(near_full_level_i) |->
    near_full_o == (wr_used_o >= near_full_level_i)) else $error("near full flag wrong");
  a_near_empty_level: assert property ($past(rst_b_i) && $stable(near_empty_level_i) |->
    near_empty_o == (rd_used_o < near_empty_level_i)) else $error("near empty flag wrong");
  a_sync_clear_all: assert property (sclr_i |=> wr_used_o == 6'h00 && rd_used_o == 6'h00
    && !rd_valid_o && wr_ready_o) else $error("clear left words behind");
  a_ready_valid_count: assert property (wr_ready_o == (wr_used_o != 6'h20)
    && rd_valid_o == (rd_used_o != 6'h00)) else $error("ready or valid disagrees with count");

  // main scenarios reached
  c_full_refused: cover property (wr_req_i && !wr_ready_o && !rd_req_i);
  c_combined_full: cover property (wr_req_i && rd_req_i && !wr_ready_o);
  c_sync_clear: cover property (sclr_i && rd_valid_o);
endmodule // fifo_opts_chk

bind fifo_build_options_and_thresholds fifo_opts_chk #(.WR_WHEN_FULL(WR_WHEN_FULL)) u_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .sclr_i(sclr_i),
  .wr_req_i(wr_req_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .wr_used_o(wr_used_o),
  .rd_req_i(rd_req_i), .rd_valid_o(rd_valid_o), .rd_used_o(rd_used_o), .rd_data_o(rd_data_o),
  .near_full_level_i(near_full_level_i), .near_empty_level_i(near_empty_level_i),
  .near_full_o(near_full_o), .near_empty_o(near_empty_o)
);
`default_nettype wire

// ---- tb/stream_ends.sv ----
// producer and consumer logic facing the buffer
// assumes the same clock as the buffer
`timescale 1ns/1ns
`default_nettype none
// ======================================================================
// request driver
module stream_ends
  import fifo_opts_pkg::*;
(
  // clock
  input wire logic clock_i,
  // requests towards the buffer
  output logic wr_req_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic rd_req_o
);
  // idle at time zero
  initial begin
    wr_req_o = 1'b0;
    rd_req_o = 1'b0;
    wr_data_o = 8'h00;
  end

  // one request cycle held edge to edge; same clock so related
  task automatic op(input logic wr, input logic rd, input logic [DATA_W-1:0] data);
    @(posedge clock_i);
    #1;
    wr_req_o = wr;
    rd_req_o = rd;
    wr_data_o = data;
    @(posedge clock_i);
    #1;
    wr_req_o = 1'b0;
    rd_req_o = 1'b0;
    wr_data_o = ~data; // stale word never repeats
  endtask
endmodule // stream_ends
`default_nettype wire
